/* hdl/msz_top.sv */
// Memory size select block: one selection register on AXI4-Lite plus decode.
// Assumes a single clock, synchronous active-low reset, one write and one read in flight.
// Function
// (R1) Reset loads the selection register with CFH, a prohibited combination.
// (R2) Software writes the selection register only with a whole-byte access.
// (R3) Software must replace the prohibited reset value with a valid one at start-up.
// (R4) Bits 7..5: 000 gives 768 bytes, 010 gives 512 bytes, else prohibited.
// (R5) Bits 3..0: 0010 8 KB, 0100 16 KB, 0110 24 KB, else prohibited.
// (R6) Software writes 42H, 04H or 06H to mimic the three smaller variants.
// (R7) Visible program store and fast memory are limited to the selected capacities.
// (R8) Bit 4 is held at zero and reads back as zero.
`timescale 1ns/10ps
module msz_top (
  input  wire logic        CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic [15:0] AWADDR_IN,
  input  wire logic        AWVALID_IN,
  output logic             AWREADY_OUT,
  input  wire logic [31:0] WDATA_IN,
  input  wire logic [3:0]  WSTRB_IN,
  input  wire logic        WVALID_IN,
  output logic             WREADY_OUT,
  output logic [1:0]       BRESP_OUT,
  output logic             BVALID_OUT,
  input  wire logic        BREADY_IN,
  input  wire logic [15:0] ARADDR_IN,
  input  wire logic        ARVALID_IN,
  output logic             ARREADY_OUT,
  output logic [31:0]      RDATA_OUT,
  output logic [1:0]       RRESP_OUT,
  output logic             RVALID_OUT,
  input  wire logic        RREADY_IN,
  input  wire logic [15:0] PROG_ADDR_IN,
  input  wire logic [15:0] FAST_ADDR_IN,
  output logic             PROG_HIT_OUT,
  output logic             FAST_HIT_OUT,
  output logic [15:0]      PROG_BYTES_OUT,
  output logic [9:0]       FAST_BYTES_OUT,
  output logic             CONFIG_OK_OUT
);
  msz_pkg::msz_state_t st_ff;
  msz_pkg::msz_state_t nxt_st;
  msz_dec_if           dec_bus ();
  logic                aw_take;
  logic                w_take;
  logic                ar_take;
  logic [31:0]         status_word;

  // Decoder sees the stored byte only, never a half-written value
  assign dec_bus.size_sel  = st_ff.size_sel;
  assign dec_bus.prog_addr = PROG_ADDR_IN;
  assign dec_bus.fast_addr = FAST_ADDR_IN;

  msz_decode u_decode (
    .dec (dec_bus)
  );

  // Handshake outputs; a channel is closed while its item or the response is pending
  assign AWREADY_OUT = !st_ff.aw_held && !st_ff.bvalid;
  assign WREADY_OUT  = !st_ff.w_held && !st_ff.bvalid;
  assign ARREADY_OUT = !st_ff.rvalid;
  assign aw_take     = AWVALID_IN && AWREADY_OUT;
  assign w_take      = WVALID_IN && WREADY_OUT;
  assign ar_take     = ARVALID_IN && ARREADY_OUT;

  // Registered answers
  assign BVALID_OUT = st_ff.bvalid;
  assign BRESP_OUT  = st_ff.bresp;
  assign RVALID_OUT = st_ff.rvalid;
  assign RDATA_OUT  = st_ff.rdata;
  assign RRESP_OUT  = st_ff.rresp;

  // Decoded view of the memory map
  assign PROG_HIT_OUT   = dec_bus.prog_hit;        // [R7]
  assign FAST_HIT_OUT   = dec_bus.fast_hit;        // [R7]
  assign PROG_BYTES_OUT = dec_bus.prog_bytes;
  assign FAST_BYTES_OUT = dec_bus.fast_bytes;
  assign CONFIG_OK_OUT  = dec_bus.prog_ok && dec_bus.fast_ok;

  // Status word lets software confirm its setting took a legal shape
  always_comb begin
    status_word                                = 32'h0000_0000;
    status_word[msz_pkg::STAT_FAST_OK_POS]     = dec_bus.fast_ok;
    status_word[msz_pkg::STAT_PROG_OK_POS]     = dec_bus.prog_ok;
    status_word[msz_pkg::STAT_ALL_OK_POS]      = dec_bus.prog_ok && dec_bus.fast_ok; // [R3]
  end

  // Next-state logic for the whole slave
  always_comb begin
    nxt_st = st_ff;
    // Capture address and data independently, in either order
    if (aw_take) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.aw_addr = AWADDR_IN;
    end
    if (w_take) begin
      nxt_st.w_held = 1'b1;
      nxt_st.w_data = WDATA_IN;
      nxt_st.w_strb = WSTRB_IN;
    end
    // Retire the response once the master has taken it
    if (st_ff.bvalid && BREADY_IN) begin
      nxt_st.bvalid = 1'b0;
    end
    // Perform the write once both halves are held
    if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid) begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      nxt_st.bresp   = msz_pkg::RESP_OKAY;
      if (st_ff.aw_addr[15:2] == msz_pkg::OFS_SIZE_SEL[15:2]) begin
        // Only the low byte lane counts; a write without it is dropped, not merged
        if (st_ff.w_strb[0]) begin // [R2]
          nxt_st.size_sel = st_ff.w_data[7:0] & msz_pkg::SIZE_SEL_WMASK; // [R8] [R6]
        end
      end else if (st_ff.aw_addr[15:2] != msz_pkg::OFS_SIZE_STATUS[15:2]) begin
        nxt_st.bresp = msz_pkg::RESP_SLVERR; // Unmapped address
      end
    end
    // Reads
    if (st_ff.rvalid && RREADY_IN) begin
      nxt_st.rvalid = 1'b0;
    end
    if (ar_take) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = msz_pkg::RESP_OKAY;
      nxt_st.rdata  = 32'h0000_0000;
      if (ARADDR_IN[15:2] == msz_pkg::OFS_SIZE_SEL[15:2]) begin
        nxt_st.rdata[7:0] = st_ff.size_sel & msz_pkg::SIZE_SEL_WMASK; // [R8]
      end else if (ARADDR_IN[15:2] == msz_pkg::OFS_SIZE_STATUS[15:2]) begin
        nxt_st.rdata = status_word;
      end else begin
        nxt_st.rresp = msz_pkg::RESP_SLVERR;
      end
    end
  end

  // State register; reset value of the selection byte is prohibited on purpose
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      st_ff          <= '0;
      st_ff.size_sel <= msz_pkg::SIZE_SEL_RESET; // [R1]
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

/* hdl/msz_pkg.sv */
// Constants and types shared by the memory size select block.
// Assumes a 32-bit AXI4-Lite master and a 16-bit processor address space.
package msz_pkg;
  // Register byte addresses
  localparam logic [15:0] OFS_SIZE_SEL      = 16'hfff0;
  localparam logic [15:0] OFS_SIZE_STATUS   = 16'hfff4;
  // Reset value of the selection register, a prohibited pair of sizes
  localparam logic [7:0]  SIZE_SEL_RESET    = 8'hcf;
  // Field positions inside the selection register
  localparam int          FAST_FIELD_LSB    = 5;
  localparam int          FAST_FIELD_MSB    = 7;
  localparam int          ZERO_BIT_POS      = 4;
  localparam int          PROG_FIELD_LSB    = 0;
  localparam int          PROG_FIELD_MSB    = 3;
  localparam logic [7:0]  SIZE_SEL_WMASK    = 8'hef;
  // Fast memory field encodings
  localparam logic [2:0]  FAST_768          = 3'h0;
  localparam logic [2:0]  FAST_512          = 3'h2;
  // Program store field encodings
  localparam logic [3:0]  PROG_8K           = 4'h2;
  localparam logic [3:0]  PROG_16K          = 4'h4;
  localparam logic [3:0]  PROG_24K          = 4'h6;
  // Capacities in bytes
  localparam logic [9:0]  FAST_BYTES_768    = 10'h300;
  localparam logic [9:0]  FAST_BYTES_512    = 10'h200;
  localparam logic [15:0] PROG_BYTES_8K     = 16'h2000;
  localparam logic [15:0] PROG_BYTES_16K    = 16'h4000;
  localparam logic [15:0] PROG_BYTES_24K    = 16'h6000;
  // Fast memory grows downward from this last address
  localparam logic [15:0] FAST_TOP_ADDR     = 16'hfeff;
  // Status register bit positions
  localparam int          STAT_FAST_OK_POS  = 0;
  localparam int          STAT_PROG_OK_POS  = 1;
  localparam int          STAT_ALL_OK_POS   = 2;
  // AXI response codes
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  // Whole state of the register slave
  typedef struct packed {
    logic        aw_held;
    logic [15:0] aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [7:0]  size_sel;
  } msz_state_t;
endpackage

/* hdl/msz_dec_if.sv */
// Carrier between the register slave and the size decoder.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/10ps
interface msz_dec_if;
  logic [7:0]  size_sel;
  logic [15:0] prog_addr;
  logic [15:0] fast_addr;
  logic        fast_ok;
  logic        prog_ok;
  logic [9:0]  fast_bytes;
  logic [15:0] prog_bytes;
  logic        prog_hit;
  logic        fast_hit;

  modport dec (
    input  size_sel, prog_addr, fast_addr,
    output fast_ok, prog_ok, fast_bytes, prog_bytes, prog_hit, fast_hit
  );
  modport ctl (
    output size_sel, prog_addr, fast_addr,
    input  fast_ok, prog_ok, fast_bytes, prog_bytes, prog_hit, fast_hit
  );
endinterface

/* hdl/msz_decode.sv */
// Size decoder: turns the selection byte into capacities and window checks.
// Assumes the selection byte comes straight from a register; purely combinational.
`timescale 1ns/10ps
module msz_decode (
  msz_dec_if.dec dec
);
  logic [2:0] fast_field;
  logic [3:0] prog_field;

  assign fast_field = dec.size_sel[msz_pkg::FAST_FIELD_MSB:msz_pkg::FAST_FIELD_LSB];
  assign prog_field = dec.size_sel[msz_pkg::PROG_FIELD_MSB:msz_pkg::PROG_FIELD_LSB];

  // Fast memory capacity; any other pattern exposes nothing
  always_comb begin
    dec.fast_ok    = 1'b1;
    dec.fast_bytes = 10'h000;
    case (fast_field)
      msz_pkg::FAST_768: dec.fast_bytes = msz_pkg::FAST_BYTES_768; // [R4]
      msz_pkg::FAST_512: dec.fast_bytes = msz_pkg::FAST_BYTES_512; // [R4]
      default:           dec.fast_ok    = 1'b0;                    // [R4]
    endcase
  end

  // Program store capacity
  always_comb begin
    dec.prog_ok    = 1'b1;
    dec.prog_bytes = 16'h0000;
    case (prog_field)
      msz_pkg::PROG_8K:  dec.prog_bytes = msz_pkg::PROG_BYTES_8K;  // [R5]
      msz_pkg::PROG_16K: dec.prog_bytes = msz_pkg::PROG_BYTES_16K; // [R5]
      msz_pkg::PROG_24K: dec.prog_bytes = msz_pkg::PROG_BYTES_24K; // [R5]
      default:           dec.prog_ok    = 1'b0;                    // [R5]
    endcase
  end

  // Window checks; program store starts at zero, fast memory ends at the top address.
  // A prohibited setting hides the whole region so stray software fails loudly.
  always_comb begin
    dec.prog_hit = dec.prog_ok && (dec.prog_addr < dec.prog_bytes);                  // [R7]
    dec.fast_hit = dec.fast_ok && (dec.fast_addr <= msz_pkg::FAST_TOP_ADDR) &&
                   ((msz_pkg::FAST_TOP_ADDR - dec.fast_addr) < {6'h00, dec.fast_bytes}); // [R7]
  end
endmodule

/* tb/msz_checker.sv */
// Assertions on the size select block ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module msz_checker (
  input wire logic        CLK_IN,
  input wire logic        RST_N_IN,
  input wire logic [15:0] PROG_ADDR_IN,
  input wire logic [15:0] FAST_ADDR_IN,
  input wire logic        PROG_HIT_OUT,
  input wire logic        FAST_HIT_OUT,
  input wire logic [15:0] PROG_BYTES_OUT,
  input wire logic [9:0]  FAST_BYTES_OUT,
  input wire logic        CONFIG_OK_OUT,
  input wire logic [31:0] RDATA_OUT,
  input wire logic        RVALID_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // Decoded sizes and window checks must agree with each other
  property p_rst; $past(!RST_N_IN) |-> !CONFIG_OK_OUT && !PROG_BYTES_OUT && !FAST_BYTES_OUT; endproperty
  property p_ok; CONFIG_OK_OUT == (FAST_BYTES_OUT != 0 && PROG_BYTES_OUT != 0); endproperty
  property p_fast; FAST_BYTES_OUT inside {10'h0, 10'h300, 10'h200}; endproperty
  property p_prog; PROG_BYTES_OUT inside {16'h0, 16'h2000, 16'h4000, 16'h6000}; endproperty
  property p_phit; PROG_HIT_OUT == (PROG_ADDR_IN < PROG_BYTES_OUT); endproperty
  property p_fhit; FAST_HIT_OUT == (FAST_ADDR_IN <= 16'hfeff && 16'hfeff - FAST_ADDR_IN < FAST_BYTES_OUT); endproperty
  // Unused byte bits and the zero bit never read as one
  property p_b4; $rose(RVALID_OUT) |-> RDATA_OUT[31:8] == 0 && !RDATA_OUT[4]; endproperty
  a_rst: assert property (p_rst) else $error("reset value not prohibited");
  a_ok: assert property (p_ok) else $error("config ok mismatch");
  a_fast: assert property (p_fast) else $error("bad fast size");
  a_prog: assert property (p_prog) else $error("bad program size");
  a_phit: assert property (p_phit) else $error("program window wrong");
  a_fhit: assert property (p_fhit) else $error("fast window wrong");
  a_b4: assert property (p_b4) else $error("zero bits read as one");
  c_ok: cover property (CONFIG_OK_OUT && FAST_BYTES_OUT == 10'h200);
  c_phit: cover property (PROG_HIT_OUT);
  c_fhit: cover property (FAST_HIT_OUT);
endmodule
bind msz_top msz_checker msz_checker_i (.CLK_IN, .RST_N_IN, .PROG_ADDR_IN, .FAST_ADDR_IN, .PROG_HIT_OUT,
  .FAST_HIT_OUT, .PROG_BYTES_OUT, .FAST_BYTES_OUT, .CONFIG_OK_OUT, .RDATA_OUT, .RVALID_OUT);

/* tb/tb_top.sv */
// Self-checking bench for the size select block.
// Assumes the package and msz_top are compiled first.
`timescale 1ns/10ps
module tb_top;
  logic        CLK_IN = 1'b0, RST_N_IN = 1'b0, AWVALID_IN, WVALID_IN, BREADY_IN, ARVALID_IN, RREADY_IN;
  logic        AWREADY_OUT, WREADY_OUT, BVALID_OUT, ARREADY_OUT, RVALID_OUT;
  logic        PROG_HIT_OUT, FAST_HIT_OUT, CONFIG_OK_OUT;
  logic [15:0] AWADDR_IN, ARADDR_IN, PROG_ADDR_IN, FAST_ADDR_IN, PROG_BYTES_OUT;
  logic [31:0] WDATA_IN, RDATA_OUT;
  logic [3:0]  WSTRB_IN;
  logic [1:0]  BRESP_OUT, RRESP_OUT;
  logic [9:0]  FAST_BYTES_OUT;
  logic [33:0] exp_q[$];
  logic [7:0]  vals[5] = '{8'h42, 8'h04, 8'h06, 8'h23, 8'he0};
  int          failures = 0, checked = 0;
  msz_top msz_top_i (.*);
  // Free-running 100 MHz clock
  initial forever #5 CLK_IN = ~CLK_IN;
  task automatic chk(string nm, logic [33:0] s, logic [33:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_of_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Upper data bytes are random noise the block must ignore
  task automatic wr(logic [15:0] a, logic [7:0] d, logic [3:0] s, logic [1:0] r);
    exp_q.push_back({r, 32'h0});
    @(posedge CLK_IN);
    AWADDR_IN <= a;
    WDATA_IN <= {24'($urandom), d};
    WSTRB_IN <= s;
    AWVALID_IN <= 1'b1;
    WVALID_IN <= 1'b1;
    BREADY_IN <= 1'b1;
    do begin
      @(posedge CLK_IN);
      if (AWREADY_OUT) AWVALID_IN <= 1'b0;
      if (WREADY_OUT) WVALID_IN <= 1'b0;
    end while (!BVALID_OUT);
    BREADY_IN <= 1'b0;
  endtask
  task automatic rd(logic [15:0] a, logic [31:0] d, logic [1:0] r);
    exp_q.push_back({r, d});
    @(posedge CLK_IN);
    ARADDR_IN <= a;
    ARVALID_IN <= 1'b1;
    RREADY_IN <= 1'b1;
    do begin
      @(posedge CLK_IN);
      if (ARREADY_OUT) ARVALID_IN <= 1'b0;
    end while (!RVALID_OUT);
    RREADY_IN <= 1'b0;
  endtask
  // Expected sizes come from the field encodings, then windows are probed at random
  task automatic sz(logic [7:0] v);
    logic [9:0]  f;
    logic [15:0] p;
    f = v[7:5] == 3'h0 ? 10'h300 : v[7:5] == 3'h2 ? 10'h200 : 10'h0;
    p = v[3:0] == 4'h2 ? 16'h2000 : v[3:0] == 4'h4 ? 16'h4000 : v[3:0] == 4'h6 ? 16'h6000 : 16'h0;
    @(posedge CLK_IN);
    PROG_ADDR_IN <= 16'($urandom % 32768);
    FAST_ADDR_IN <= 16'hfeff - 16'($urandom % 1024);
    @(negedge CLK_IN);
    chk("bytes", {FAST_BYTES_OUT, PROG_BYTES_OUT}, {f, p});
    chk("ok", CONFIG_OK_OUT, f != 0 && p != 0);
    chk("phit", PROG_HIT_OUT, PROG_ADDR_IN < p);
    chk("fhit", FAST_HIT_OUT, 16'hfeff - FAST_ADDR_IN < f);
    rd(16'hfff0, {24'h0, v & 8'hef}, 2'h0);
    rd(16'hfff4, {29'h0, f != 0 && p != 0, p != 0, f != 0}, 2'h0);
  endtask
  // Answers are matched in order against the notes left by the drivers
  always @(posedge CLK_IN) begin
    if (BVALID_OUT && BREADY_IN) chk("bresp", {BRESP_OUT, 32'h0}, exp_q.pop_front());
    if (RVALID_OUT && RREADY_IN) chk("read", {RRESP_OUT, RDATA_OUT}, exp_q.pop_front());
  end
  // Watchdog, far beyond the expected run length
  initial begin
    #20us;
    failures++;
    end_of_test();
  end
  initial begin
    {AWVALID_IN, WVALID_IN, BREADY_IN, ARVALID_IN, RREADY_IN} = 5'h0;
    {AWADDR_IN, ARADDR_IN, PROG_ADDR_IN, FAST_ADDR_IN} = 64'h0;
    WDATA_IN = 32'h0;
    WSTRB_IN = 4'h0;
    void'($urandom(75));
    repeat (4) @(posedge CLK_IN);
    RST_N_IN <= 1'b1;
    sz(8'hcf);
    foreach (vals[i]) begin
      wr(16'hfff0, vals[i] | 8'h10, 4'h1, 2'h0);
      sz(vals[i]);
    end
    wr(16'hfff0, 8'h42, 4'he, 2'h0);
    wr(16'hfff4, 8'h42, 4'h1, 2'h0);
    wr(16'hfff8, 8'h42, 4'h1, 2'h2);
    rd(16'hfff8, 32'h0, 2'h2);
    sz(8'he0);
    @(posedge CLK_IN);
    RST_N_IN <= 1'b0;
    @(posedge CLK_IN);
    RST_N_IN <= 1'b1;
    sz(8'hcf);
    repeat (2) @(posedge CLK_IN);
    end_of_test();
  end
endmodule
